// ==== hw/sample_fifo.sv ====
// Sample FIFO between sequencer and result memory writer
`timescale 1ns/1ps
module sample_fifo #(
  parameter int width = 25,
  parameter int depth = 16
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [width-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Read accept
  output logic [width-1:0] out_data // Head word
);
  localparam int aw = $clog2(depth);
  initial
  begin
    if (depth < 2 || (1 << aw) != depth)
      $error("sample_fifo depth must be a power of two >= 2");
  end
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_q;
  logic [aw:0] rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_q - rd_q) != (aw+1)'(depth);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[aw-1:0]];
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q[aw-1:0]] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ==== hw/sample_seq.sv ====
// Sampling sequencer: input selector, conversion timing, chopper and result writes
//
// Function
// R1 - Regular states select six phase inputs in order
// R2 - Alternate: thermal in state0, aux in state2
// R3 - Voltage inputs never replaced in alternate cycles
// R4 - States per cycle field picks 2,3,4,6
// R5 - Host settings alt, formula, states govern sequencer
// R6 - Latch alternate request on request rising edge
// R7 - Finish cycle, one alternate cycle, then regular
// R8 - Sequencer steps on 32768 Hz slow clock
// R9 - Issue compute engine pass start
// R10 - Start conversions, drive chopper polarity
// R11 - Resolution bit selects 21 or 22 bits
// R12 - Conversion two or three slow cycles
// R13 - Write filter result to input's word
// R14 - Chopper field: normal, inverted or toggling
// R15 - Toggle chopper only at cycle boundaries
// R16 - Host requests alternate cycles only rarely
// R17 - Host disables aux comparator interrupts when sampling
// R18 - Results at words 0x00 to 0x07
// R19 - Engine pass launched when state 0 begins
// R20 - Chopper encoding 00/11 toggle, 01, 10
// R21 - Settings sampled only at cycle boundary
`timescale 1ns/1ps
module sample_seq #(
  parameter int slow_div = sample_seq_pkg::slow_div_count, // System clocks per slow tick
  parameter int result_width = 22, // Filter output word width
  parameter int fifo_depth = 16 // Result buffer depth
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic reg_we, // Host register write strobe
  input wire logic [15:0] reg_addr, // Host register byte address
  input wire logic [7:0] reg_wdata, // Host write data
  output logic [7:0] reg_rdata, // Host read data
  output logic [2:0] input_select, // Analog selector code
  output logic conv_start, // Converter and filter start pulse
  output logic chop_swap_signal, // Reference chopper polarity
  output logic engine_start, // Compute engine pass start pulse
  output logic [2:0] meter_formula, // Formula select to engine
  output logic [1:0] mux_state, // Current selector state low bits
  output logic [2:0] state_index, // Current selector state
  input wire logic filter_done, // Filter result ready pulse
  input wire logic [result_width-1:0] filter_result, // Filter raw result
  output logic dmem_we, // Data memory write strobe
  output logic [2:0] dmem_addr, // Data memory word address
  output logic [result_width-1:0] dmem_wdata, // Data memory write word
  input wire logic dmem_ready // Data memory accepts write
);
  initial
  begin
    if (slow_div < 2 || result_width < 22 || fifo_depth < 2)
      $error("sample_seq parameters out of range");
  end

  // ----------------------------------------
  // Host registers
  // ----------------------------------------
  logic [2:0] formula_q;
  logic [1:0] states_q;
  logic [1:0] chop_q;
  logic resolution_q;
  logic alt_req_q;
  logic alt_req_prev_q;
  logic alt_pending_q;
  wire wr_formula = reg_we && reg_addr == sample_seq_pkg::formula_addr;
  wire wr_mux = reg_we && reg_addr == sample_seq_pkg::mux_cfg_addr;
  wire wr_adc = reg_we && reg_addr == sample_seq_pkg::adc_cfg_addr;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      formula_q <= sample_seq_pkg::formula_rst;
      states_q <= sample_seq_pkg::states_rst;
      chop_q <= sample_seq_pkg::chop_rst;
      resolution_q <= sample_seq_pkg::resolution_rst;
      alt_req_q <= 1'b0;
    end
    else
    begin
      if (wr_formula)
        formula_q <= reg_wdata[sample_seq_pkg::formula_lsb +: 3]; // R5
      if (wr_mux)
      begin
        states_q <= reg_wdata[sample_seq_pkg::states_lsb +: 2]; // R4
        chop_q <= reg_wdata[sample_seq_pkg::chop_lsb +: 2]; // R14
      end
      if (wr_adc)
      begin
        resolution_q <= reg_wdata[sample_seq_pkg::resolution_bit]; // R11
        alt_req_q <= reg_wdata[sample_seq_pkg::alt_req_bit];
      end
    end
  end
  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_addr == sample_seq_pkg::formula_addr)
      reg_rdata[sample_seq_pkg::formula_lsb +: 3] = formula_q;
    else if (reg_addr == sample_seq_pkg::mux_cfg_addr)
    begin
      reg_rdata[sample_seq_pkg::states_lsb +: 2] = states_q;
      reg_rdata[sample_seq_pkg::chop_lsb +: 2] = chop_q;
    end
    else if (reg_addr == sample_seq_pkg::adc_cfg_addr)
    begin
      reg_rdata[sample_seq_pkg::resolution_bit] = resolution_q;
      reg_rdata[sample_seq_pkg::alt_req_bit] = alt_req_q;
    end
  end

  // ----------------------------------------
  // Slow tick divider
  // ----------------------------------------
  localparam int dw = $clog2(slow_div);
  logic [dw-1:0] div_q;
  wire tick = div_q == dw'(slow_div - 1);
  always_ff @(posedge clk)
  begin
    if (sys_rst || tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1; // R8
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  function automatic logic [2:0] state_count(input logic [1:0] f);
    case (f)
      2'h0: state_count = 3'h2;
      2'h1: state_count = 3'h3;
      2'h2: state_count = 3'h4;
      default: state_count = 3'h6;
    endcase
  endfunction

  function automatic logic [2:0] pick_input(input logic [2:0] s, input logic alt);
    case (s)
      3'h0: pick_input = alt ? 3'(sample_seq_pkg::thermal_sensor)
                             : 3'(sample_seq_pkg::phase_a_current); // R1 R2
      3'h2: pick_input = alt ? 3'(sample_seq_pkg::aux_monitor_input)
                             : 3'(sample_seq_pkg::phase_b_current); // R1 R2
      default: pick_input = s; // R1 R3
    endcase
  endfunction

  typedef enum logic [1:0] {idle_st, start_st, convert_st} seq_state_type;
  seq_state_type st_q;
  logic [2:0] state_q;
  logic [1:0] ticks_q;
  logic alt_cycle_q;
  logic [1:0] cyc_states_q;
  logic cyc_res_q;
  logic [1:0] cyc_chop_q;
  logic [2:0] cyc_formula_q;
  logic toggle_q;
  logic chop_swap_signal_q;
  logic [2:0] sel_q;
  logic conv_q;
  logic engine_q;

  wire rise = alt_req_q && !alt_req_prev_q;
  wire [1:0] conv_len = cyc_res_q ? sample_seq_pkg::conv_long_ticks
                                  : sample_seq_pkg::conv_short_ticks; // R12
  wire conv_end = st_q == convert_st && tick && ticks_q == conv_len - 2'h1;
  wire last_state = state_q == state_count(cyc_states_q) - 3'h1; // R4
  wire boundary = st_q == start_st && state_q == 3'h0;
  wire toggling = !(chop_q == sample_seq_pkg::chop_normal ||
                    chop_q == sample_seq_pkg::chop_inverted); // R20

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      alt_req_prev_q <= 1'b0;
      alt_pending_q <= 1'b0;
    end
    else
    begin
      alt_req_prev_q <= alt_req_q;
      if (rise)
        alt_pending_q <= 1'b1; // R6
      else if (boundary)
        alt_pending_q <= 1'b0; // R7
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= idle_st;
      state_q <= 3'h0;
      ticks_q <= 2'h0;
      alt_cycle_q <= 1'b0;
      cyc_states_q <= sample_seq_pkg::states_rst;
      cyc_res_q <= sample_seq_pkg::resolution_rst;
      cyc_chop_q <= sample_seq_pkg::chop_rst;
      cyc_formula_q <= sample_seq_pkg::formula_rst;
      toggle_q <= 1'b0;
      sel_q <= 3'h0;
      conv_q <= 1'b0;
      engine_q <= 1'b0;
    end
    else
    begin
      conv_q <= 1'b0;
      engine_q <= 1'b0;
      case (st_q)
        idle_st:
          if (tick)
            st_q <= start_st;
        start_st:
        begin
          // Entered on a slow tick and left at once, so states stay whole slow cycles apart
          if (state_q == 3'h0)
          begin
            // Cycle boundary: settings and the alternate choice are frozen here
            cyc_states_q <= states_q; // R21
            cyc_res_q <= resolution_q; // R21
            cyc_chop_q <= chop_q; // R21
            cyc_formula_q <= formula_q; // R21
            alt_cycle_q <= alt_pending_q && !rise; // R7
            if (toggling)
              toggle_q <= ~toggle_q; // R15
            engine_q <= 1'b1; // R9 R19
            sel_q <= pick_input(3'h0, alt_pending_q && !rise);
          end
          else
            sel_q <= pick_input(state_q, alt_cycle_q);
          conv_q <= 1'b1; // R10
          ticks_q <= 2'h0;
          st_q <= convert_st;
        end
        convert_st:
          if (tick)
          begin
            if (conv_end)
            begin
              state_q <= last_state ? 3'h0 : state_q + 3'h1;
              // Next state starts one clock after this end tick
              st_q <= start_st;
            end
            else
              ticks_q <= ticks_q + 2'h1;
          end
        default:
          st_q <= idle_st;
      endcase
    end
  end

  // Toggled state survives mode changes so polarity stays alternating
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chop_swap_signal_q <= 1'b0;
    else
    begin
      case (cyc_chop_q)
        sample_seq_pkg::chop_normal: chop_swap_signal_q <= 1'b0; // R14
        sample_seq_pkg::chop_inverted: chop_swap_signal_q <= 1'b1; // R14
        default: chop_swap_signal_q <= toggle_q; // R15
      endcase
    end
  end

  assign input_select = sel_q; // R10
  assign conv_start = conv_q;
  assign engine_start = engine_q;
  assign chop_swap_signal = chop_swap_signal_q; // R10
  assign meter_formula = cyc_formula_q;
  assign state_index = state_q;
  assign mux_state = state_q[1:0];

  // ----------------------------------------
  // Result path
  // ----------------------------------------
  // 21-bit mode drops the filter's lowest bit
  wire [result_width-1:0] res_word = cyc_res_q ? filter_result
      : {filter_result[result_width-1:1], 1'b0}; // R11
  logic fifo_ready;
  logic fifo_valid;
  logic [result_width+2:0] fifo_out;
  sample_fifo #(
    .width(result_width + 3),
    .depth(fifo_depth)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(filter_done),
    .in_ready(fifo_ready),
    .in_data({sel_q, res_word}), // R13
    .out_valid(fifo_valid),
    .out_ready(dmem_ready),
    .out_data(fifo_out)
  );
  assign dmem_we = fifo_valid; // R13
  assign dmem_addr = fifo_out[result_width +: 3]; // R18
  assign dmem_wdata = fifo_out[result_width-1:0];
endmodule

// ==== hw/sample_seq_pkg.sv ====
// Package: register map, fields, input codes and timing for the sampling sequencer
package sample_seq_pkg;
  // Register byte addresses
  localparam logic [15:0] formula_addr = 16'h2000;
  localparam logic [15:0] mux_cfg_addr = 16'h2002;
  localparam logic [15:0] adc_cfg_addr = 16'h2005;
  // Field positions
  localparam int formula_lsb = 5;
  localparam int states_lsb = 6;
  localparam int chop_lsb = 4;
  localparam int alt_req_bit = 2;
  localparam int resolution_bit = 4;
  // Reset values
  localparam logic [2:0] formula_rst = 3'h0;
  localparam logic [1:0] states_rst = 2'h3;
  localparam logic [1:0] chop_rst = 2'h0;
  localparam logic resolution_rst = 1'b0;
  // Chopper field encoding
  localparam logic [1:0] chop_toggle_a = 2'h0;
  localparam logic [1:0] chop_normal = 2'h1;
  localparam logic [1:0] chop_inverted = 2'h2;
  // Converter inputs, values are also the result word addresses
  typedef enum logic [2:0] {
    phase_a_current = 3'h0,
    phase_a_voltage = 3'h1,
    phase_b_current = 3'h2,
    phase_b_voltage = 3'h3,
    phase_c_current = 3'h4,
    phase_c_voltage = 3'h5,
    thermal_sensor = 3'h6,
    aux_monitor_input = 3'h7
  } input_sel_type;
  // Timing
  localparam int slow_clock_hz = 32768;
  localparam int sys_clock_hz = 125000000;
  localparam int slow_div_count = sys_clock_hz / slow_clock_hz;
  localparam logic [1:0] conv_short_ticks = 2'h2;
  localparam logic [1:0] conv_long_ticks = 2'h3;
endpackage

// ==== verification/dmem_model.sv ====
// Filter and data memory stand-in facing the sequencer
`timescale 1ns/1ps
module dmem_model (
  input wire logic clk, // Clock
  input wire logic stall, // Refuse writes
  input wire logic clear, // Zero memory
  input wire logic conv_start, // Start pulse
  input wire logic [2:0] input_select, // Selected input
  output logic filter_done, // Result pulse
  output logic [21:0] filter_result, // Raw result
  input wire logic dmem_we, // Write strobe
  input wire logic [2:0] dmem_addr, // Word
  input wire logic [21:0] dmem_wdata, // Data
  output logic dmem_ready, // Accept
  output logic [21:0] mem [8] // Contents
);
  int wait_q = 0;
  logic [2:0] sel_q = 3'h0;
  initial filter_done = 1'b0;
  initial filter_result = 22'h0;
  initial mem = '{default: 22'h0};
  assign dmem_ready = !stall;
  // Result inside the shortest conversion; the bus churns outside the pulse
  always @(posedge clk)
  begin
    filter_done <= wait_q == 1;
    filter_result <= wait_q == 1 ? {sel_q, 18'h2a5a5, 1'b1} : ~filter_result;
    wait_q <= conv_start ? 10 : (wait_q > 0 ? wait_q - 1 : 0);
    if (conv_start)
      sel_q <= input_select;
    if (clear)
      mem <= '{default: 22'h0};
    else if (dmem_we && dmem_ready)
      mem[dmem_addr] <= dmem_wdata;
  end
endmodule

// ==== verification/sample_seq_properties.sv ====
// Port-level properties of the sampling sequencer
`timescale 1ns/1ps
module sample_seq_properties #(
  parameter int slow_div = 8, // Clocks per slow tick
  parameter int result_width = 22 // Result width
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [2:0] input_select, // Selector
  input wire logic conv_start, // Start pulse
  input wire logic chop_swap_signal, // Chopper
  input wire logic engine_start, // Pass start
  input wire logic [2:0] meter_formula, // Formula
  input wire logic [2:0] state_index, // State
  input wire logic dmem_we, // Write strobe
  input wire logic [2:0] dmem_addr, // Word
  input wire logic [result_width-1:0] dmem_wdata, // Data
  input wire logic dmem_ready // Ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] gap_q;
  logic seen_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || conv_start)
      gap_q <= 8'h0;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h1;
    seen_q <= !sys_rst && (seen_q || conv_start);
  end
  sel_code_a:
  assert property (conv_start |-> input_select == state_index
    || (state_index == 3'h0 && input_select == 3'h6)
    || (state_index == 3'h2 && input_select == 3'h7)) else $error("bad selector code");
  volt_kept_a:
  assert property (conv_start && state_index[0] |-> input_select == state_index)
    else $error("voltage input replaced");
  eng_state0_a:
  assert property (engine_start |-> conv_start && state_index == 3'h0)
    else $error("engine start outside state 0");
  state0_eng_a:
  assert property (conv_start && state_index == 3'h0 |-> engine_start)
    else $error("state 0 without engine start");
  conv_gap_a:
  assert property (conv_start && seen_q |-> gap_q == 2 * slow_div - 1
    || gap_q == 3 * slow_div - 1) else $error("bad conversion length");
  chop_edge_a:
  assert property ($changed(chop_swap_signal) |-> engine_start || $past(engine_start))
    else $error("chopper moved inside a cycle");
  formula_hold_a:
  assert property ($changed(meter_formula) |-> engine_start || $past(engine_start))
    else $error("formula moved inside a cycle");
  start_pulse_a:
  assert property (conv_start |=> !conv_start && !engine_start) else $error("start too long");
  write_hold_a:
  assert property (dmem_we && !dmem_ready |=> dmem_we && $stable(dmem_addr)
    && $stable(dmem_wdata)) else $error("stalled write changed");
endmodule
bind sample_seq sample_seq_properties #(.slow_div(slow_div), .result_width(result_width))
  i_props (.clk(clk), .sys_rst(sys_rst), .input_select(input_select),
  .conv_start(conv_start), .chop_swap_signal(chop_swap_signal),
  .engine_start(engine_start), .meter_formula(meter_formula), .state_index(state_index),
  .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
  .dmem_ready(dmem_ready));

// ==== verification/sample_seq_tb.sv ====
// Self-checking bench for the sampling sequencer
`timescale 1ns/1ps
module sample_seq_tb;
  typedef struct {logic [7:0] cfg; int n; logic sw; logic tog;} row_type;
  row_type rows [4] = '{'{8'h10, 2, 0, 0}, '{8'h60, 3, 1, 0}, '{8'h80, 4, 0, 1},
    '{8'hf0, 6, 0, 1}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_we = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0] reg_wdata = 8'h0;
  logic stall = 1'b0;
  logic clear = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] input_select, meter_formula, state_index, dmem_addr;
  logic conv_start, chop_swap_signal, engine_start, filter_done, dmem_we, dmem_ready, s0;
  logic [1:0] mux_state;
  logic [21:0] filter_result, dmem_wdata;
  logic [21:0] mem [8];
  logic [2:0] sel_q [$];
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int len = 0;
  always #4 clk = ~clk;
  sample_seq #(.slow_div(8)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .input_select(input_select), .conv_start(conv_start), .chop_swap_signal(chop_swap_signal),
    .engine_start(engine_start), .meter_formula(meter_formula), .mux_state(mux_state),
    .state_index(state_index), .filter_done(filter_done), .filter_result(filter_result),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_ready(dmem_ready));
  dmem_model i_mem (.clk(clk), .stall(stall), .clear(clear), .conv_start(conv_start),
    .input_select(input_select), .filter_done(filter_done), .filter_result(filter_result),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_ready(dmem_ready), .mem(mem));
  function automatic logic [21:0] word(input int i, input logic r);
    return {i[2:0], 18'h2a5a5, r};
  endfunction
  function automatic logic [2:0] pick(input int i, input logic alt);
    if (alt && i == 0)
      return 3'h6;
    if (alt && i == 2)
      return 3'h7;
    return i[2:0];
  endfunction
  task finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input string what, input logic [21:0] exp, input logic [21:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_we, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    reg_we = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    #1 check("register", e, reg_rdata);
  endtask
  // Waits for a cycle boundary, then lets the monitor log state 0
  task wait_eng();
    int n;
    n = 0;
    @(negedge clk);
    while (engine_start !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    #1;
  endtask
  task sync();
    wait_eng();
    sel_q = {input_select};
    len = 0;
    @(negedge clk);
    clear = 1'b1;
    @(negedge clk);
    clear = 1'b0;
  endtask
  task cyc_chk(input int n, input logic alt, input int ticks);
    wait_eng();
    check("states", n + 1, sel_q.size());
    for (int i = 0; i < n; i++)
      check("select", pick(i, alt), sel_q[i]);
    check("length", n * ticks * 8, len);
    sel_q = {input_select};
    len = 0;
  endtask
  always @(negedge clk)
  begin
    len = len + 1;
    if (conv_start === 1'b1)
      sel_q.push_back(input_select);
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rd(16'h2000, 8'h00);
    rd(16'h2002, 8'hc0);
    rd(16'h2005, 8'h00);
    wr(16'h2000, 8'hff);
    wr(16'h2001, 8'hff);
    rd(16'h2000, 8'he0);
    rd(16'h2001, 8'h00);
    foreach (rows[r])
    begin
      wr(16'h2002, rows[r].cfg);
      sync();
      s0 = chop_swap_signal;
      cyc_chk(rows[r].n, 0, 2);
      @(negedge clk);
      check("formula", 3'h7, meter_formula);
      check("chop", rows[r].tog ? !s0 : rows[r].sw, chop_swap_signal);
      for (int i = 0; i < 8; i++)
        check("word", i < rows[r].n ? word(i, 0) : 22'h0, mem[i]);
    end
    // Request pulse: two clocks high, dropped on the next write
    sync();
    wr(16'h2005, 8'h04);
    wr(16'h2005, 8'h00);
    cyc_chk(6, 0, 2);
    cyc_chk(6, 1, 2);
    check("thermal", word(6, 0), mem[6]);
    check("aux", word(7, 0), mem[7]);
    cyc_chk(6, 0, 2);
    wr(16'h2005, 8'h10);
    sync();
    cyc_chk(6, 0, 3);
    check("long", word(5, 1), mem[5]);
    stall = 1'b1;
    sync();
    cyc_chk(6, 0, 3);
    check("held", 1'b1, dmem_we);
    stall = 1'b0;
    repeat (16) @(negedge clk);
    check("drained", 1'b0, dmem_we);
    check("stalled", word(4, 1), mem[4]);
    repeat (7) @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset", 5'h0, {conv_start, engine_start, dmem_we, chop_swap_signal, 1'b0});
    sys_rst = 1'b0;
    rd(16'h2002, 8'hc0);
    sync();
    cyc_chk(6, 0, 2);
    finish_test();
  end
endmodule
